// ---- inc/scp_cfg.svh ----
// constants for the status register and program counter core logic
`ifndef SCP_CFG_SVH
`define SCP_CFG_SVH
`define SCP_ADDR_STATUS   5'h03
`define SCP_ADDR_LATCH    5'h02
`define SCP_BIT_CARRY     3'h0
`define SCP_BIT_NIBBLE    3'h1
`define SCP_BIT_ZERO      3'h2
`define SCP_BIT_PDOWN     3'h3
`define SCP_BIT_TIMEOUT   3'h4
`define SCP_BIT_PAGE_LO   3'h5
`define SCP_BIT_PAGE_HI   3'h6
`define SCP_BIT_SPARE     3'h7
`define SCP_STATUS_RESET  8'h18
`define SCP_PC_RESET      11'h7FF
`endif

// ---- inc/scp_pkg.sv ----
// types for the status register and program counter core logic
package scp_pkg;
	typedef enum logic [3:0] {
		scp_op_nop,
		scp_op_move_acc_to_file,
		scp_op_clear_file,
		scp_op_add_file,
		scp_op_subtract_file,
		scp_op_xor_file,
		scp_op_xor_literal,
		scp_op_rotate_right,
		scp_op_rotate_left,
		scp_op_bit_clear,
		scp_op_bit_set,
		scp_op_jump,
		scp_op_call,
		scp_op_watchdog_kick,
		scp_op_sleep
	} scp_op_t;
endpackage

// ---- rtl/scp_alu.sv ----
// arithmetic and logic unit with flag generation
`timescale 1ns/1ps
`include "scp_cfg.svh"
module scp_alu (
	input  wire scp_pkg::scp_op_t op,
	input  wire logic [7:0]       acc,
	input  wire logic [7:0]       file_val,
	input  wire logic [7:0]       literal,
	input  wire logic [2:0]       bit_sel,
	input  wire logic             carry_in,
	output logic [7:0]            result,
	output logic                  zero,
	output logic                  nibble_out_bit,
	output logic                  carry_out
);
	import scp_pkg::*;

	wire [8:0] add_sum  = {1'b0, file_val} + {1'b0, acc};
	wire [4:0] add_nib  = {1'b0, file_val[3:0]} + {1'b0, acc[3:0]};
	// subtract as f + ~w + 1 so carry means no borrow
	wire [8:0] sub_sum  = {1'b0, file_val} + {1'b0, ~acc} + 9'h001;
	wire [4:0] sub_nib  = {1'b0, file_val[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
	wire [7:0] bit_mask = 8'h01 << bit_sel;

	always_comb begin
		result         = file_val;
		nibble_out_bit = 1'b0;
		carry_out      = carry_in;
		unique case (op)
			scp_op_move_acc_to_file: result = acc;
			scp_op_clear_file:       result = 8'h00;
			scp_op_add_file: begin
				result         = add_sum[7:0];
				nibble_out_bit = add_nib[4];
				carry_out      = add_sum[8];
			end
			scp_op_subtract_file: begin
				result         = sub_sum[7:0];
				nibble_out_bit = sub_nib[4];
				carry_out      = sub_sum[8];
			end
			scp_op_xor_file:    result = acc ^ file_val;
			scp_op_xor_literal: result = acc ^ literal;
			scp_op_rotate_right: begin
				result    = {carry_in, file_val[7:1]};
				carry_out = file_val[0];
			end
			scp_op_rotate_left: begin
				result    = {file_val[6:0], carry_in};
				carry_out = file_val[7];
			end
			scp_op_bit_clear: result = file_val & ~bit_mask;
			scp_op_bit_set:   result = file_val | bit_mask;
			default:          result = file_val;
		endcase
	end

	assign zero = (result == 8'h00);
endmodule

// ---- rtl/scp_core.sv ----
// status register, accumulator and program counter sequencing
`timescale 1ns/1ps
`include "scp_cfg.svh"
module scp_core #(
	parameter bit PAGED = 1'b1
) (
	input  wire logic             sys_clk,
	input  wire logic             sys_rst,
	input  wire logic             instr_valid,
	input  wire scp_pkg::scp_op_t instr_op,
	input  wire logic [4:0]       file_addr,
	input  wire logic             dest_file,
	input  wire logic [8:0]       instr_target,
	input  wire logic [2:0]       bit_sel,
	input  wire logic [7:0]       literal,
	input  wire logic [7:0]       file_rd_data,
	input  wire logic             wdt_timeout,
	output logic [7:0]            core_status_flags,
	output logic [10:0]           program_counter,
	output logic [7:0]            acc,
	output logic [7:0]            file_wr_data,
	output logic [4:0]            file_wr_addr,
	output logic                  file_wr_en,
	output logic [7:0]            rd_data
);
	import scp_pkg::*;

	// ************************************************
	// decode
	// ************************************************
	function automatic logic sets_arith(input scp_op_t o);
		return o inside {scp_op_add_file, scp_op_subtract_file, scp_op_rotate_right, scp_op_rotate_left};
	endfunction

	function automatic logic sets_zero(input scp_op_t o);
		return o inside {scp_op_add_file, scp_op_subtract_file, scp_op_xor_file,
			scp_op_xor_literal, scp_op_clear_file};
	endfunction

	function automatic logic writes_file(input scp_op_t o, input logic d);
		return (o inside {scp_op_move_acc_to_file, scp_op_clear_file, scp_op_bit_clear, scp_op_bit_set})
			|| (d && (o inside {scp_op_add_file, scp_op_subtract_file, scp_op_xor_file,
			scp_op_rotate_right, scp_op_rotate_left}));
	endfunction

	wire       run        = instr_valid;
	wire       is_status  = (file_addr == `SCP_ADDR_STATUS);
	wire       is_latch   = (file_addr == `SCP_ADDR_LATCH);
	wire       wr_file    = run && writes_file(instr_op, dest_file);
	wire       wr_acc     = run && !writes_file(instr_op, dest_file)
		&& (instr_op inside {scp_op_add_file, scp_op_subtract_file, scp_op_xor_file,
		scp_op_xor_literal, scp_op_rotate_right, scp_op_rotate_left});
	wire       do_arith   = run && sets_arith(instr_op);
	wire       do_zero    = run && sets_zero(instr_op);

	// status and latch reads come from this block, other files from outside
	wire [7:0] operand = is_status ? core_status_flags
		: (is_latch ? program_counter[7:0] : file_rd_data);

	wire [7:0] alu_result;
	wire       alu_zero;
	wire       alu_nibble;
	wire       alu_carry;

	scp_alu scp_alu_inst (
		.op             (instr_op),
		.acc            (acc),
		.file_val       (operand),
		.literal        (literal),
		.bit_sel        (bit_sel),
		.carry_in       (core_status_flags[`SCP_BIT_CARRY]),
		.result         (alu_result),
		.zero           (alu_zero),
		.nibble_out_bit (alu_nibble),
		.carry_out      (alu_carry)
	);

	// ************************************************
	// status register next value
	// ************************************************
	logic [7:0] next_status;
	always_comb begin
		next_status = core_status_flags;
		// direct write lands only on writable bits
		if (wr_file && is_status) begin
			next_status[`SCP_BIT_SPARE]   = alu_result[7];
			next_status[`SCP_BIT_PAGE_HI] = alu_result[6];
			next_status[`SCP_BIT_PAGE_LO] = alu_result[5];
			if (!sets_arith(instr_op) && !sets_zero(instr_op)) begin
				next_status[2:0] = alu_result[2:0];
			end
			// timeout and power-down keep their value here
		end
		// flag updates from the result override the written data
		if (do_zero || do_arith) begin
			if (do_zero) begin
				next_status[`SCP_BIT_ZERO] = alu_zero;
			end
			if (instr_op inside {scp_op_add_file, scp_op_subtract_file}) begin
				next_status[`SCP_BIT_NIBBLE] = alu_nibble;
			end
			if (do_arith) begin
				next_status[`SCP_BIT_CARRY] = alu_carry;
			end
		end
		if (run && instr_op == scp_op_watchdog_kick) begin
			next_status[`SCP_BIT_TIMEOUT] = 1'b1;
			next_status[`SCP_BIT_PDOWN]   = 1'b1;
		end
		if (run && instr_op == scp_op_sleep) begin
			next_status[`SCP_BIT_TIMEOUT] = 1'b1;
			next_status[`SCP_BIT_PDOWN]   = 1'b0;
		end
		// time-out event wins over an instruction in the same cycle
		if (wdt_timeout) begin
			next_status[`SCP_BIT_TIMEOUT] = 1'b0;
		end
	end

	// ************************************************
	// program counter next value
	// ************************************************
	wire [1:0]  page      = PAGED ? core_status_flags[6:5] : 2'b00;
	wire        latch_wr  = wr_file && is_latch;
	wire [10:0] pc_inc    = program_counter + 11'h001;
	wire [10:0] pc_jump   = {page, instr_target};
	// bit 8 forced low: calls and computed jumps reach first 256 words of a page
	wire [10:0] pc_call   = {page, 1'b0, literal};
	wire [10:0] pc_latch  = {page, 1'b0, alu_result};

	logic [10:0] next_pc;
	always_comb begin
		next_pc = program_counter;
		if (run) begin
			if (instr_op == scp_op_jump) begin
				next_pc = pc_jump;
			end else if (instr_op == scp_op_call) begin
				next_pc = pc_call;
			end else if (latch_wr) begin
				next_pc = pc_latch;
			end else begin
				next_pc = pc_inc;
			end
		end
	end

	// ************************************************
	// registers
	// ************************************************
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			core_status_flags <= `SCP_STATUS_RESET;
			program_counter   <= `SCP_PC_RESET;
			acc               <= 8'h00;
			file_wr_data      <= 8'h00;
			file_wr_addr      <= 5'h00;
			file_wr_en        <= 1'b0;
			rd_data           <= 8'h00;
		end else begin
			core_status_flags <= next_status;
			program_counter   <= next_pc;
			if (wr_acc) begin
				acc <= alu_result;
			end
			// status and latch are held here, so not forwarded outside
			file_wr_en   <= wr_file && !is_status && !is_latch;
			file_wr_addr <= file_addr;
			file_wr_data <= alu_result;
			rd_data      <= operand;
		end
	end
endmodule

// ---- tb/scp_core_monitor.sv ----
// assertions on the status and program counter core ports
`timescale 1ns/1ps
module scp_core_monitor #(
	parameter bit PAGED = 1'b1
) (
	input wire logic	sys_clk,
	input wire logic	sys_rst,
	input wire logic	instr_valid,
	input wire scp_pkg::scp_op_t	instr_op,
	input wire logic [4:0]	file_addr,
	input wire logic [8:0]	instr_target,
	input wire logic [7:0]	literal,
	input wire logic	wdt_timeout,
	input wire logic [7:0]	core_status_flags,
	input wire logic [10:0]	program_counter,
	input wire logic [7:0]	acc
);
	import scp_pkg::*;
	// *****
	// properties
	// *****
	// a watchdog pulse also moves bit 4, so such cycles are left out
	wire logic [7:0]	st = core_status_flags;
	wire logic	ok = instr_valid && !wdt_timeout;
	wire logic	to_st = ok && file_addr == 5'h03;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	sequence s_op(scp_op_t o);
		ok && instr_op == o;
	endsequence
	property p_rst;
		$past(sys_rst) |-> st == 8'h18 && program_counter == 11'h7FF && acc == 8'h00;
	endproperty
	a_rst: assert property (p_rst) else $error("reset values wrong");
	property p_xorl;
		s_op(scp_op_xor_literal) |=> acc == ($past(acc) ^ $past(literal)) && st[2] == (acc == 8'h00)
			&& st[1:0] == $past(st[1:0]) && program_counter == $past(program_counter) + 11'h001;
	endproperty
	a_xorl: assert property (p_xorl) else $error("xor literal wrong");
	property p_jmp;
		s_op(scp_op_jump) |=> program_counter[8:0] == $past(instr_target)
			&& (!PAGED || program_counter[10:9] == $past(st[6:5]));
	endproperty
	a_jmp: assert property (p_jmp) else $error("jump target wrong");
	property p_call;
		s_op(scp_op_call) |=> program_counter[8:0] == {1'b0, $past(literal)}
			&& (!PAGED || program_counter[10:9] == $past(st[6:5]));
	endproperty
	a_call: assert property (p_call) else $error("call target wrong");
	property p_mov;
		to_st && instr_op == scp_op_move_acc_to_file |=> st == {$past(acc[7:5]), $past(st[4:3]), $past(acc[2:0])};
	endproperty
	a_mov: assert property (p_mov) else $error("status write wrong");
	property p_clr;
		to_st && instr_op == scp_op_clear_file |=> st == {3'b000, $past(st[4:3]), 1'b1, $past(st[1:0])};
	endproperty
	a_clr: assert property (p_clr) else $error("status clear wrong");
	property p_slp;
		s_op(scp_op_sleep) |=> st[4:3] == 2'b10;
	endproperty
	a_slp: assert property (p_slp) else $error("sleep flags wrong");
	property p_wdt;
		wdt_timeout |=> !st[4];
	endproperty
	a_wdt: assert property (p_wdt) else $error("timeout flag not cleared");
endmodule
bind scp_core scp_core_monitor #(.PAGED(PAGED)) scp_core_monitor_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
	.instr_valid(instr_valid), .instr_op(instr_op), .file_addr(file_addr), .instr_target(instr_target),
	.literal(literal), .wdt_timeout(wdt_timeout), .core_status_flags(core_status_flags),
	.program_counter(program_counter), .acc(acc));

// ---- tb/scp_core_tb.sv ----
// self-checking bench for the status and program counter core
`timescale 1ns/1ps
module scp_core_tb;
	import scp_pkg::*;
	logic	sys_clk = 1'b0;
	logic	sys_rst = 1'b1;
	logic	instr_valid = 1'b0;
	scp_op_t	instr_op = scp_op_nop;
	logic [4:0]	file_addr = 5'h00;
	logic	dest_file = 1'b0;
	logic [8:0]	instr_target = 9'h000;
	logic [2:0]	bit_sel = 3'h0;
	logic [7:0]	literal = 8'h00;
	logic [7:0]	file_rd_data = 8'h00;
	logic	wdt_timeout = 1'b0;
	wire logic [7:0]	st, acc, wr_data, rd;
	wire logic [10:0]	pc;
	wire logic [4:0]	wr_addr;
	wire logic	wr_en;
	int	errors = 0;
	int	n_tests = 0;
	int	cyc = 0;
	scp_core scp_core_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
		.instr_op(instr_op), .file_addr(file_addr), .dest_file(dest_file), .instr_target(instr_target),
		.bit_sel(bit_sel), .literal(literal), .file_rd_data(file_rd_data), .wdt_timeout(wdt_timeout),
		.core_status_flags(st), .program_counter(pc), .acc(acc), .file_wr_data(wr_data),
		.file_wr_addr(wr_addr), .file_wr_en(wr_en), .rd_data(rd));
	initial begin
		forever #4 sys_clk = ~sys_clk;
	end
	// *****
	// tasks
	// *****
	task automatic chk(string name, logic [10:0] seen, logic [10:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// one instruction held for one cycle, then valid drops and the task returns; the next call's leading negedge wait gives the idle cycle
	task automatic run(scp_op_t op, logic [4:0] fa, logic d, logic [8:0] v, logic [7:0] fd);
		@(negedge sys_clk);
		instr_op = op;
		file_addr = fa;
		dest_file = d;
		instr_target = v;
		literal = v[7:0];
		bit_sel = v[2:0];
		file_rd_data = fd;
		instr_valid = 1'b1;
		@(negedge sys_clk);
		instr_valid = 1'b0;
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 500) begin
			errors++;
			wrap_up();
		end
	end
	initial begin
		repeat (8) @(negedge sys_clk);
		sys_rst = 1'b0;
		chk("status", 11'(st), 11'h018);
		chk("pc", pc, 11'h7FF);
		run(scp_op_xor_literal, 5'h00, 1'b0, 9'h0B5, 8'h00);
		chk("pc", pc, 11'h000);
		run(scp_op_xor_literal, 5'h00, 1'b0, 9'h0AF, 8'h00);
		chk("acc", 11'(acc), 11'h01A);
		run(scp_op_xor_literal, 5'h00, 1'b0, 9'h01A, 8'h00);
		chk("zero", 11'(st[2]), 11'h001);
		$display("xor literal test done");
		run(scp_op_xor_literal, 5'h00, 1'b0, 9'h0E5, 8'h00);
		run(scp_op_move_acc_to_file, 5'h03, 1'b1, 9'h000, 8'h00);
		chk("status", 11'(st), 11'h0FD);
		run(scp_op_clear_file, 5'h03, 1'b1, 9'h000, 8'h00);
		chk("status", 11'(st), 11'h01D);
		run(scp_op_bit_set, 5'h03, 1'b1, 9'h006, 8'h00);
		run(scp_op_bit_set, 5'h03, 1'b1, 9'h005, 8'h00);
		chk("status", 11'(st), 11'h07D);
		$display("status write test done");
		run(scp_op_jump, 5'h00, 1'b0, 9'h1A5, 8'h00);
		chk("pc", pc, 11'h7A5);
		run(scp_op_call, 5'h00, 1'b0, 9'h03C, 8'h00);
		chk("pc", pc, 11'h63C);
		run(scp_op_move_acc_to_file, 5'h02, 1'b1, 9'h000, 8'h00);
		chk("pc", pc, 11'h6E5);
		$display("branch test done");
		run(scp_op_bit_clear, 5'h03, 1'b1, 9'h006, 8'h00);
		chk("status", 11'(st), 11'h03D);
		run(scp_op_sleep, 5'h00, 1'b0, 9'h000, 8'h00);
		chk("wake", 11'(st[4:3]), 11'h002);
		run(scp_op_watchdog_kick, 5'h00, 1'b0, 9'h000, 8'h00);
		chk("wake", 11'(st[4:3]), 11'h003);
		@(negedge sys_clk);
		wdt_timeout = 1'b1;
		@(negedge sys_clk);
		wdt_timeout = 1'b0;
		chk("wake", 11'(st[4:3]), 11'h001);
		run(scp_op_xor_literal, 5'h00, 1'b0, 9'h0EA, 8'h00);
		run(scp_op_add_file, 5'h05, 1'b0, 9'h000, 8'h01);
		chk("flags", 11'({acc, st[2:0]}), 11'h082);
		run(scp_op_subtract_file, 5'h05, 1'b0, 9'h000, 8'h10);
		chk("flags", 11'({acc, st[2:0]}), 11'h007);
		run(scp_op_rotate_left, 5'h05, 1'b0, 9'h000, 8'h03);
		chk("rotate", 11'({acc, st[0]}), 11'h00E);
		run(scp_op_xor_file, 5'h05, 1'b1, 9'h000, 8'hAF);
		for (int i = 0; i < 4 && wr_en !== 1'b1; i++) @(negedge sys_clk);
		chk("write", 11'({wr_en, wr_addr}), 11'h025);
		chk("write", 11'(wr_data), 11'h0A8);
		chk("acc", 11'(acc), 11'h007);
		chk("read", 11'(rd), 11'h0AF);
		$display("arithmetic test done");
		wrap_up();
	end
endmodule
